// ===== hdl/mcc_mode_clock_ctrl.sv
/*
 * Mode and clock control: decodes strap pins into operating mode, bus
 * width and PLL multiplier, runs the peripheral prescaler and gates the
 * six high-current timer pins through the oscillator halt detector.
 * Assumes all inputs are synchronous to i_ref_clk and that the straps
 * are held steady while power is on.
 */

module mcc_mode_clock_ctrl #(
   parameter int unsigned HALT_WIN    = mcc_pkg::HALT_WIN_CYC,
   parameter bit          LARGE_PKG   = 1'b1
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   input  wire logic        i_op_mode_pin_0,
   input  wire logic        i_op_mode_pin_1,
   input  wire logic        i_clk_mode_pin_0,
   input  wire logic        i_clk_mode_pin_1,
   input  wire logic        i_flash_write_protect_n,
   input  wire logic        i_ext_clock_in,
   input  wire logic        i_standby,
   input  wire logic [5:0]  i_timer_pin_oe_n,
   output logic      [3:0]  o_op_mode,
   output logic             o_mode_undefined,
   output logic             o_rom_enable,
   output logic      [1:0]  o_cs0_bus_width,
   output logic             o_rom_bus_32,
   output logic             o_ext_addr_enable,
   output logic             o_all_ports_gpio,
   output logic      [2:0]  o_pll_mult,
   output logic             o_pll_reserved,
   output logic      [12:0] o_presc_tick,
   output logic      [5:0]  o_timer_pin_oe_n,
   output logic             o_timer_pins_hiz,
   output logic             o_osc_halted,
   output logic             o_osc_fail
);

   typedef struct packed {
      mcc_pkg::mcc_mode_type mode;
      logic                  undef;
      logic                  rom;
      logic [1:0]            cs0w;
      logic                  rom32;
      logic                  ext_addr;
      logic                  gpio;
      logic [2:0]            mult;
      logic                  pll_rsvd;
      logic [12:0]           presc;
      logic [12:0]           tick;
      logic [5:0]            oe_n;
      logic                  hiz;
      logic                  halted;
      logic                  fail;
   } mcc_top_type;

   mcc_top_type s_q;
   mcc_top_type s_d;
   mcc_halt_if  hif ();

   logic [mcc_pkg::PRESC_TAPS-1:0] tick_d;

   // Tap k pulses when the low k+1 prescaler bits are all one
   for (genvar k = 0; k < mcc_pkg::PRESC_TAPS; k++) begin : g_tick
      assign tick_d[k] = &s_q.presc[k:0];
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic mcc_pkg::mcc_mode_type decode_mode(
      input logic       fwp_n,
      input logic [1:0] up,
      input logic [1:0] lo
   );
      mcc_pkg::mcc_mode_type m;
      m = mcc_pkg::MCC_MODE_UNDEF;
      if (fwp_n && up == 2'h3 && lo == 2'h3) begin
         m = mcc_pkg::MCC_MODE_ROM_PROG;
      end else if (fwp_n && up == 2'h3 && lo == 2'h1) begin
         m = mcc_pkg::MCC_MODE_FLASH_PGM;
      end else if (fwp_n) begin
         m = mcc_pkg::mcc_mode_type'({2'h0, lo});
      end else if (lo == 2'h0) begin
         m = mcc_pkg::MCC_MODE_BOOT;
      end else if (lo == 2'h2) begin
         m = mcc_pkg::MCC_MODE_USER_PROG;
      end
      return m;
   endfunction

   function automatic logic [2:0] pll_mult(input logic [1:0] up);
      logic [2:0] r;
      r = mcc_pkg::MULT_X1;
      if (up == mcc_pkg::PLL_X2) begin
         r = mcc_pkg::MULT_X2;
      end else if (up == mcc_pkg::PLL_X4) begin
         r = mcc_pkg::MULT_X4;
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   assign hif.ext_clock_in = i_ext_clock_in;
   assign hif.standby      = i_standby;

   mcc_halt_det #(
      .WIN_CYC (HALT_WIN)
   ) u_halt (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .hif       (hif)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [1:0] up;
      logic [1:0] lo;
      up = {i_clk_mode_pin_1, i_clk_mode_pin_0};
      lo = {i_op_mode_pin_1, i_op_mode_pin_0};
      s_d = s_q;

      s_d.mode  = decode_mode(i_flash_write_protect_n, up, lo);
      s_d.undef = s_d.mode == mcc_pkg::MCC_MODE_UNDEF;
      s_d.rom      = 1'b1;
      s_d.cs0w     = mcc_pkg::BUS_NONE;
      s_d.rom32    = 1'b0;
      s_d.ext_addr = 1'b1;
      s_d.gpio     = 1'b0;
      case (s_d.mode)
         mcc_pkg::MCC_MODE_MCU0: begin
            s_d.rom  = 1'b0;
            s_d.cs0w = LARGE_PKG ? mcc_pkg::BUS_16 : mcc_pkg::BUS_8;
         end
         mcc_pkg::MCC_MODE_MCU1: begin
            s_d.rom  = 1'b0;
            s_d.cs0w = LARGE_PKG ? mcc_pkg::BUS_32 : mcc_pkg::BUS_16;
         end
         mcc_pkg::MCC_MODE_MCU2: begin
            s_d.rom32 = 1'b1;
         end
         mcc_pkg::MCC_MODE_SINGLE: begin
            s_d.ext_addr = 1'b0;
            s_d.gpio     = 1'b1;
         end
         mcc_pkg::MCC_MODE_ROM_PROG,
         mcc_pkg::MCC_MODE_FLASH_PGM: begin
            s_d.ext_addr = 1'b0;
         end
         mcc_pkg::MCC_MODE_BOOT,
         mcc_pkg::MCC_MODE_USER_PROG: begin
            s_d.rom32 = 1'b1;
         end
         default: begin
            s_d.rom      = 1'b0;
            s_d.ext_addr = 1'b0;
         end
      endcase

      // Clock mode only meaningful in MCU modes 0 to 3
      if (s_d.mode <= mcc_pkg::MCC_MODE_SINGLE) begin
         s_d.mult     = pll_mult(up);
         s_d.pll_rsvd = up == mcc_pkg::PLL_RSVD;
      end else begin
         s_d.mult     = mcc_pkg::MULT_X1;
         s_d.pll_rsvd = 1'b0;
      end

      // Free-running divider; bit k toggles at phi/2^(k+1)
      s_d.presc = s_q.presc + 13'h0001;
      s_d.tick  = tick_d;

      s_d.hiz    = hif.pins_hiz;
      s_d.oe_n   = hif.pins_hiz ? mcc_pkg::TIMER_PINS_ALL
                                : i_timer_pin_oe_n;
      s_d.halted = hif.halt_seen;
      s_d.fail   = hif.latched_fail;

      if (i_reset) begin
         s_d.presc = mcc_pkg::PRESC_RST;
         s_d.tick  = '0;
         s_d.oe_n  = mcc_pkg::TIMER_PINS_ALL;
         s_d.hiz   = 1'b0;
         s_d.halted = 1'b0;
         s_d.fail  = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////////////
   assign o_op_mode         = s_q.mode;
   assign o_mode_undefined  = s_q.undef;
   assign o_rom_enable      = s_q.rom;
   assign o_cs0_bus_width   = s_q.cs0w;
   assign o_rom_bus_32      = s_q.rom32;
   assign o_ext_addr_enable = s_q.ext_addr;
   assign o_all_ports_gpio  = s_q.gpio;
   assign o_pll_mult        = s_q.mult;
   assign o_pll_reserved    = s_q.pll_rsvd;
   assign o_presc_tick      = s_q.tick;
   assign o_timer_pin_oe_n  = s_q.oe_n;
   assign o_timer_pins_hiz  = s_q.hiz;
   assign o_osc_halted      = s_q.halted;
   assign o_osc_fail        = s_q.fail;

endmodule

// ===== pkg/mcc_pkg.sv
/*
 * Constants and types of the mode and clock control block.
 * Assumes a single 10 MHz system clock and synchronous reset.
 */
package mcc_pkg;

   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int unsigned HALT_WIN_NS   = 1000;
   localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
   localparam int unsigned HALT_WIN_CYC  =
      (HALT_WIN_NS / CLK_PERIOD_NS) < 1 ? 1 : HALT_WIN_NS / CLK_PERIOD_NS;

   localparam int unsigned PRESC_W   = 13;
   localparam int unsigned PRESC_TAPS = 13;
   localparam logic [12:0] PRESC_RST = 13'h0000;

   localparam logic [1:0] PLL_X1 = 2'h0;
   localparam logic [1:0] PLL_X2 = 2'h1;
   localparam logic [1:0] PLL_X4 = 2'h2;
   localparam logic [1:0] PLL_RSVD = 2'h3;

   localparam logic [2:0] MULT_X1 = 3'h1;
   localparam logic [2:0] MULT_X2 = 3'h2;
   localparam logic [2:0] MULT_X4 = 3'h4;

   localparam logic [1:0] BUS_NONE = 2'h0;
   localparam logic [1:0] BUS_8    = 2'h1;
   localparam logic [1:0] BUS_16   = 2'h2;
   localparam logic [1:0] BUS_32   = 2'h3;

   localparam logic [5:0] TIMER_PINS_ALL = 6'h3F;

   typedef enum logic [3:0] {
      MCC_MODE_MCU0      = 4'h0,
      MCC_MODE_MCU1      = 4'h1,
      MCC_MODE_MCU2      = 4'h2,
      MCC_MODE_SINGLE    = 4'h3,
      MCC_MODE_ROM_PROG  = 4'h4,
      MCC_MODE_BOOT      = 4'h5,
      MCC_MODE_USER_PROG = 4'h6,
      MCC_MODE_FLASH_PGM = 4'h7,
      MCC_MODE_UNDEF     = 4'hF
   } mcc_mode_type;

   typedef enum logic [1:0] {
      MCC_HD_RUN     = 2'h0,
      MCC_HD_HALTED  = 2'h1,
      MCC_HD_STANDBY = 2'h2
   } mcc_hd_state_type;

endpackage

// ===== pkg/mcc_halt_if.sv
/*
 * Carrier between the top and the halt detector.
 * Assumes both ends sit in the one clock domain.
 */
interface mcc_halt_if;
   logic ext_clock_in;
   logic standby;
   logic halt_seen;
   logic pins_hiz;
   logic latched_fail;

   modport top (output ext_clock_in, output standby,
                input halt_seen, input pins_hiz, input latched_fail);
   modport det (input ext_clock_in, input standby,
                output halt_seen, output pins_hiz, output latched_fail);
endinterface

// ===== hdl/mcc_halt_det.sv
/*
 * Oscillator halt detector: watches the external clock sample for change
 * and forces the high-current timer pins to high impedance.
 * Assumes ext_clock_in is already synchronous to i_ref_clk.
 */
module mcc_halt_det #(
   parameter int unsigned WIN_CYC = mcc_pkg::HALT_WIN_CYC
) (
   input  wire logic    i_ref_clk,
   input  wire logic    i_reset,
   mcc_halt_if.det      hif
);

   localparam int unsigned CW = $clog2(WIN_CYC + 1);

   typedef struct packed {
      mcc_pkg::mcc_hd_state_type st;
      logic                      prev;
      logic [CW-1:0]             cnt;
      logic                      fail;
   } mcc_hd_type;

   mcc_hd_type s_q;
   mcc_hd_type s_d;
   logic       edge_seen;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d       = s_q;
      edge_seen = hif.ext_clock_in != s_q.prev;
      s_d.prev  = hif.ext_clock_in;
      case (s_q.st)
         mcc_pkg::MCC_HD_RUN: begin
            if (hif.standby) begin
               s_d.st  = mcc_pkg::MCC_HD_STANDBY;
               s_d.cnt = '0;
            end else if (edge_seen) begin
               s_d.cnt = '0;
            end else if (s_q.cnt == CW'(WIN_CYC - 1)) begin
               s_d.st   = mcc_pkg::MCC_HD_HALTED;
               s_d.fail = 1'b1;
            end else begin
               s_d.cnt = s_q.cnt + CW'(1);
            end
         end
         mcc_pkg::MCC_HD_HALTED: begin
            s_d.cnt = '0;
            if (hif.standby) begin
               s_d.st = mcc_pkg::MCC_HD_STANDBY;
            end else if (edge_seen) begin
               s_d.st = mcc_pkg::MCC_HD_RUN;
            end
         end
         mcc_pkg::MCC_HD_STANDBY: begin
            s_d.cnt = '0;
            if (!hif.standby) begin
               s_d.st = mcc_pkg::MCC_HD_RUN;
            end
         end
         default: begin
            s_d.st = mcc_pkg::MCC_HD_RUN;
         end
      endcase
      if (i_reset) begin
         s_d.st   = mcc_pkg::MCC_HD_RUN;
         s_d.prev = 1'b0;
         s_d.cnt  = '0;
         s_d.fail = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      s_q <= s_d;
   end

   assign hif.halt_seen    = s_q.st == mcc_pkg::MCC_HD_HALTED;
   assign hif.pins_hiz     = s_q.st != mcc_pkg::MCC_HD_RUN;
   assign hif.latched_fail = s_q.fail;

endmodule

// ===== verification/mcc_asserts.sv
/* Concurrent checks on the ports of the mode and clock control top.
   Assumes one rising-edge clock and a synchronous active-high reset. */
module mcc_asserts #(
   parameter int unsigned HALT_WIN  = 10,
   parameter bit          LARGE_PKG = 1'h1
) (
   input wire logic        i_ref_clk,
   input wire logic        i_reset,
   input wire logic        i_op_mode_pin_0,
   input wire logic        i_op_mode_pin_1,
   input wire logic        i_clk_mode_pin_0,
   input wire logic        i_clk_mode_pin_1,
   input wire logic        i_flash_write_protect_n,
   input wire logic        i_ext_clock_in,
   input wire logic        i_standby,
   input wire logic [3:0]  o_op_mode,
   input wire logic        o_mode_undefined,
   input wire logic        o_rom_enable,
   input wire logic [1:0]  o_cs0_bus_width,
   input wire logic        o_rom_bus_32,
   input wire logic        o_ext_addr_enable,
   input wire logic        o_all_ports_gpio,
   input wire logic [2:0]  o_pll_mult,
   input wire logic        o_pll_reserved,
   input wire logic [12:0] o_presc_tick,
   input wire logic [5:0]  o_timer_pin_oe_n,
   input wire logic        o_timer_pins_hiz,
   input wire logic        o_osc_halted,
   input wire logic        o_osc_fail
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       flash_write_protect_n;
   logic [1:0] up;
   logic [1:0] lo;
   logic [7:0] still_q;
   assign flash_write_protect_n = i_flash_write_protect_n;
   assign up  = {i_clk_mode_pin_1, i_clk_mode_pin_0};
   assign lo  = {i_op_mode_pin_1, i_op_mode_pin_0};
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   // Cycles without an external clock change outside standby
   always_ff @(posedge i_ref_clk) begin
      if (i_reset || i_standby || !$stable(i_ext_clock_in))
         still_q <= 8'h00;
      else if (still_q != 8'hFF)
         still_q <= still_q + 8'h01;
   end
   ////////////////////////////////////////////////////////////////////////
   AST_MCU_MODE: assert property (flash_write_protect_n && up != 2'h3 |=>
      o_op_mode == {2'h0, $past(lo)}) else $error("mcu mode decode");
   AST_PLL: assert property (flash_write_protect_n && up != 2'h3 |=>
      o_pll_mult == (3'h1 << $past(up)) && !o_pll_reserved)
      else $error("pll multiplier decode");
   AST_BOOT: assert property (!flash_write_protect_n && lo == 2'h0 |=> o_rom_enable &&
      o_op_mode == mcc_pkg::MCC_MODE_BOOT) else $error("boot decode");
   AST_UNDEF: assert property (!flash_write_protect_n && i_op_mode_pin_0 |=>
      o_mode_undefined) else $error("undefined pattern not flagged");
   AST_PROG: assert property (flash_write_protect_n && up == 2'h3 && lo[0] |=>
      o_rom_enable && o_op_mode == ($past(lo[1]) ?
      mcc_pkg::MCC_MODE_ROM_PROG : mcc_pkg::MCC_MODE_FLASH_PGM))
      else $error("programming mode decode");
   AST_CS0_M0: assert property (o_op_mode == 4'h0 |-> !o_rom_enable &&
      o_cs0_bus_width == (LARGE_PKG ? mcc_pkg::BUS_16 : mcc_pkg::BUS_8))
      else $error("mode 0 area zero width");
   AST_CS0_M1: assert property (o_op_mode == 4'h1 |-> !o_rom_enable &&
      o_cs0_bus_width == (LARGE_PKG ? mcc_pkg::BUS_32 : mcc_pkg::BUS_16))
      else $error("mode 1 area zero width");
   AST_ROM32: assert property (o_op_mode == 4'h2 |->
      o_rom_enable && o_rom_bus_32) else $error("mode 2 rom width");
   AST_SINGLE: assert property (o_op_mode == 4'h3 |-> o_rom_enable &&
      o_all_ports_gpio && !o_ext_addr_enable) else $error("single chip");
   AST_STBY_HIZ: assert property (i_standby ##1 i_standby |=>
      o_timer_pins_hiz && o_timer_pin_oe_n == mcc_pkg::TIMER_PINS_ALL)
      else $error("standby hi-z missing");
   AST_HALT_HIZ: assert property (still_q == HALT_WIN + 4 |->
      o_osc_halted && o_timer_pin_oe_n == 6'h3F) else $error("halt hi-z");
   AST_FAIL_STICKY: assert property (o_osc_fail |=> o_osc_fail)
      else $error("fault flag dropped");
   AST_TICK0: assert property (o_presc_tick[0] |=>
      !o_presc_tick[0] ##1 o_presc_tick[0]) else $error("half rate tick");
endmodule

bind mcc_mode_clock_ctrl mcc_asserts #(
   .HALT_WIN (HALT_WIN),
   .LARGE_PKG(LARGE_PKG)
) mcc_asserts_i (
   .i_ref_clk, .i_reset, .i_op_mode_pin_0, .i_op_mode_pin_1,
   .i_clk_mode_pin_0, .i_clk_mode_pin_1, .i_flash_write_protect_n,
   .i_ext_clock_in, .i_standby, .o_op_mode, .o_mode_undefined,
   .o_rom_enable, .o_cs0_bus_width, .o_rom_bus_32, .o_ext_addr_enable,
   .o_all_ports_gpio, .o_pll_mult, .o_pll_reserved, .o_presc_tick,
   .o_timer_pin_oe_n, .o_timer_pins_hiz, .o_osc_halted, .o_osc_fail
);

// ===== verification/mcc_ext_src.sv
/* Far-side model: external clock source and board strap pins.
   Assumes the bench asks for strap changes only during power-on reset. */
module mcc_ext_src (
   input  wire logic       i_ref_clk,
   input  wire logic       i_por,
   input  wire logic       i_standby,
   input  wire logic       i_fault,
   input  wire logic [4:0] i_strap_req,
   output logic            o_ext_clock_in = 1'h1,
   output logic      [4:0] o_straps = 5'h10
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(negedge i_ref_clk) begin
      if (i_por)
         o_straps <= i_strap_req;
      if (i_standby)
         o_ext_clock_in <= 1'h1;
      else if (!i_fault)
         o_ext_clock_in <= ~o_ext_clock_in;
   end
endmodule

// ===== verification/tb_top.sv
/* Self-checking bench for the mode and clock control block.
   Assumes the far-side model supplies straps and the external clock. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned HWIN = 3;
   logic clk = 1'h0, rst = 1'h1, stby = 1'h0, fault = 1'h0;
   logic [4:0] req = 5'h10, st;
   logic [5:0] oe_n = 6'h15, oe_o;
   logic [3:0] mode;
   logic [2:0] pll;
   logic [1:0] cs0;
   logic [12:0] tick;
   logic ext, undef, rom, gpio, exta, hiz, halted, fail, r32;
   int n_mismatch = 0, cmp_count = 0, cyc = 0, n, t0;
   // Strap pattern, expected mode code, expected multiplier
   logic [11:0] tbl [10] = '{{5'h10, 4'h0, 3'h1}, {5'h15, 4'h1, 3'h2},
      {5'h1A, 4'h2, 3'h4}, {5'h13, 4'h3, 3'h1}, {5'h1F, 4'h4, 3'h1},
      {5'h1D, 4'h7, 3'h1}, {5'h00, 4'h5, 3'h1}, {5'h01, 4'hF, 3'h1},
      {5'h02, 4'h6, 3'h1}, {5'h0B, 4'hF, 3'h1}};
   always #50 clk = ~clk;
   mcc_ext_src mcc_ext_src_i (.i_ref_clk(clk), .i_por(rst),
      .i_standby(stby), .i_fault(fault), .i_strap_req(req),
      .o_ext_clock_in(ext), .o_straps(st));
   mcc_mode_clock_ctrl #(.HALT_WIN(HWIN), .LARGE_PKG(1'h1))
   mcc_mode_clock_ctrl_i (.i_ref_clk(clk), .i_reset(rst),
      .i_op_mode_pin_0(st[0]), .i_op_mode_pin_1(st[1]),
      .i_clk_mode_pin_0(st[2]), .i_clk_mode_pin_1(st[3]),
      .i_flash_write_protect_n(st[4]), .i_ext_clock_in(ext),
      .i_standby(stby), .i_timer_pin_oe_n(oe_n), .o_op_mode(mode),
      .o_mode_undefined(undef), .o_rom_enable(rom), .o_cs0_bus_width(cs0),
      .o_rom_bus_32(r32), .o_ext_addr_enable(exta), .o_all_ports_gpio(gpio),
      .o_pll_mult(pll), .o_pll_reserved(), .o_presc_tick(tick),
      .o_timer_pin_oe_n(oe_o), .o_timer_pins_hiz(hiz),
      .o_osc_halted(halted), .o_osc_fail(fail));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [13:0] ex,
                      input logic [13:0] got);
      cmp_count++;
      if (got !== ex) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic por(input logic [4:0] s);
      @(negedge clk);
      req <= s;
      rst <= 1'h1;
      repeat (2) @(negedge clk);
      rst <= 1'h0;
      repeat (3) @(negedge clk);
   endtask
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic tick_span;
      n = 0;
      t0 = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
         t0 += int'(tick[0]);
      end while (tick[12] !== 1'h1 && n < 9000);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         final_report;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(negedge clk);
      rst <= 1'h0;
      repeat (3) @(negedge clk);
      chk("oe_pass", 14'h0015, 14'(oe_o));
      foreach (tbl[k]) begin
         por(tbl[k][11:7]);
         chk("op_mode", 14'(tbl[k][6:3]), 14'(mode));
         chk("pll_mult", 14'(tbl[k][2:0]), 14'(pll));
         chk("undef", 14'(tbl[k][6:3] == 4'hF), 14'(undef));
         if (tbl[k][6:3] != 4'hF)
            chk("rom_en", 14'(tbl[k][6:3] > 4'h1), 14'(rom));
         if (tbl[k][6:3] < 4'h2)
            chk("cs0", 14'(tbl[k][3] ? 2'h3 : 2'h2), 14'(cs0));
         if (tbl[k][6:3] == 4'h3)
            chk("gpio_ext", 14'h0002, 14'({gpio, exta}));
         if (tbl[k][6:3] == 4'h2)
            chk("rom32", 14'h0001, 14'(r32));
      end
      tick_span;
      tick_span;
      chk("tick12_period", 14'(8192), 14'(n));
      chk("tick0_count", 14'(4096), 14'(t0));
      @(negedge clk);
      stby <= 1'h1;
      repeat (3) @(negedge clk);
      chk("oe_stby", 14'h003F, 14'(oe_o));
      chk("hiz_stby", 14'h0001, 14'(hiz));
      stby <= 1'h0;
      repeat (5) @(negedge clk);
      chk("oe_resume", 14'h0015, 14'(oe_o));
      chk("fail_stby", 14'h0000, 14'(fail));
      fault <= 1'h1;
      n = 0;
      while (halted !== 1'h1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk("halt_late", 14'h0001, 14'(n >= HWIN));
      chk("halted", 14'h0001, 14'(halted));
      repeat (3) @(negedge clk);
      chk("oe_halt", 14'h003F, 14'(oe_o));
      fault <= 1'h0;
      n = 0;
      while (halted !== 1'h0 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk("halt_clear", 14'h0000, 14'(halted));
      chk("fail_kept", 14'h0001, 14'(fail));
      por(5'h10);
      chk("fail_reset", 14'h0000, 14'(fail));
      final_report;
   end
endmodule
